/* File: inc/lbe_pkg.sv */
// register map, field layout, constants and types of the link lane self-test engine
package lbe_pkg;

  // ==========================================================================
  // sizes
  localparam int unsigned LANES     = 18;
  localparam int unsigned ENG_LANES = 9;
  localparam int unsigned APB_AW    = 8;

  // ==========================================================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFF_BIST_CTL   = 8'h00;
  localparam logic [7:0] OFF_PAT_CTL    = 8'h04;
  localparam logic [7:0] OFF_PBUF1      = 8'h08;
  localparam logic [7:0] OFF_MASK       = 8'h0C;
  localparam logic [7:0] OFF_INVERT     = 8'h10;
  localparam logic [7:0] OFF_PBUF2      = 8'h14;
  localparam logic [7:0] OFF_PB2_SELECT = 8'h18;
  localparam logic [7:0] OFF_PBUF_EXT   = 8'h1C;
  localparam logic [7:0] OFF_SCRAMBLE   = 8'h20;
  localparam logic [7:0] OFF_ERR_FLAGS  = 8'h24;
  localparam logic [7:0] OFF_ENGINE_CTL = 8'h28;

  // ==========================================================================
  // field positions
  localparam int unsigned RX_OFF_BIT   = 1;
  localparam int unsigned ROT_ON_BIT   = 5;
  localparam int unsigned ERR_STAT_LSB = 6;
  localparam int unsigned ERR_LANE_LSB = 8;
  localparam int unsigned TALLY_LSB    = 16;
  localparam int unsigned RUN_BIT      = 0;
  localparam int unsigned LINK32_BIT   = 2;
  localparam int unsigned GROUP_LSB    = 4;
  localparam int unsigned RING_LSB     = 6;

  // ==========================================================================
  // reset values and codes
  localparam logic [17:0] RST_MASK     = 18'h3FFFF;
  localparam logic [23:0] RST_PBUF1    = 24'hF0C3A5;
  localparam logic [23:0] RST_PBUF2    = 24'h0F3C5A;
  localparam logic [31:0] RST_PBUF_EXT = 32'h5AA5A55A;
  localparam logic        ENGINE_IS_16 = 1'b0;
  localparam logic [10:0] TALLY_MAX    = 11'h7FF;
  localparam logic [1:0]  STAT_NONE    = 2'h0;
  localparam logic [1:0]  STAT_MISCMP  = 2'h2;
  localparam logic [1:0]  STAT_CLEAR   = 2'h3;
  localparam logic [4:0]  LANE_CLEAR   = 5'h1F;
  localparam logic [1:0]  RING_16      = 2'h0;
  localparam logic [1:0]  RING_8       = 2'h1;
  localparam logic [1:0]  RING_2       = 2'h2;
  localparam logic [22:0] SCR_SEED     = 23'h7FFFFF;

  // ==========================================================================
  // pattern lengths in bit-times
  localparam logic [5:0] BUF_BITS   = 6'd40;
  localparam logic [5:0] CONST_UNIT = 6'd24;
  localparam logic [5:0] MOD_BITS   = 6'd24;

  // ==========================================================================
  // types
  typedef enum logic [1:0] {SRC_BUF, SRC_MOD, SRC_CONST} lbe_src_t;

  typedef struct packed {
    logic [4:0] const_cnt;
    logic       const_val;
    logic [6:0] mod_cnt;
    logic [2:0] mod_pick;
    logic [6:0] buf_cnt;
    logic [2:0] order;
  } lbe_pattern_control_t;

  typedef struct packed {
    logic       ctl1;
    logic [7:0] cad_hi;
    logic       ctl0;
    logic [7:0] cad_lo;
  } lbe_lanes_t;

  typedef struct packed {
    lbe_src_t   src;
    logic [5:0] ptr;
    logic       mod_bit;
    logic       const_bit;
  } lbe_beat_t;

endpackage

/* File: hdl/lbe_pat_seq.sv */
// source sequencer of the self-test engine: order, repeat counts, modulo-n pattern
`timescale 1ns/1ps
`default_nettype none
module lbe_pat_seq
  import lbe_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // control
  input  wire logic        run,
  input  wire logic        bit_en,
  input  wire lbe_pattern_control_t ctl,
  // current bit-time
  output var  lbe_beat_t   beat,
  output logic             loop_end
);

  // ==========================================================================
  // helpers
  function automatic lbe_src_t src_of(input logic [2:0] order, input logic [1:0] slot);
    lbe_src_t a;
    lbe_src_t b;
    lbe_src_t c;
    case (order)
      3'b001:  begin a = SRC_BUF;   b = SRC_CONST; c = SRC_MOD;   end
      3'b010:  begin a = SRC_MOD;   b = SRC_BUF;   c = SRC_CONST; end
      3'b011:  begin a = SRC_MOD;   b = SRC_CONST; c = SRC_BUF;   end
      3'b100:  begin a = SRC_CONST; b = SRC_BUF;   c = SRC_MOD;   end
      3'b101:  begin a = SRC_CONST; b = SRC_MOD;   c = SRC_BUF;   end
      default: begin a = SRC_BUF;   b = SRC_MOD;   c = SRC_CONST; end
    endcase
    src_of = (slot == 2'd0) ? a : (slot == 2'd1) ? b : c;
  endfunction

  function automatic logic mod_of(input logic [2:0] pick, input logic [5:0] p);
    logic [5:0] r;
    r = p % 6'd6;
    case (pick)
      3'b001:  mod_of = p[0];
      3'b010:  mod_of = p[1];
      3'b011:  mod_of = (r >= 6'd3);
      3'b100:  mod_of = p[2];
      3'b110:  mod_of = (p >= 6'd12);
      default: mod_of = 1'b0;
    endcase
  endfunction

  // ==========================================================================
  // slot, bit pointer and repeat counters
  logic [1:0] slot_q;
  logic [5:0] ptr_q;
  logic [6:0] rep_q;
  lbe_src_t   cur_src;
  logic [5:0] unit_len;
  logic [6:0] reps;
  logic       empty;
  logic       step;
  logic       last_bit;
  logic       slot_done;

  assign cur_src   = src_of(ctl.order, slot_q);
  assign unit_len  = (cur_src == SRC_BUF) ? BUF_BITS : (cur_src == SRC_MOD) ? MOD_BITS : CONST_UNIT;
  assign reps      = (cur_src == SRC_BUF) ? ctl.buf_cnt :
                     (cur_src == SRC_MOD) ? ctl.mod_cnt : {2'b00, ctl.const_cnt};
  assign empty     = (reps == 7'd0);
  assign step      = run & (empty | bit_en);
  assign last_bit  = (ptr_q == unit_len - 6'd1);
  assign slot_done = empty | (last_bit & (rep_q == reps - 7'd1));
  assign loop_end  = step & slot_done & (slot_q == 2'd2);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      slot_q <= 2'd0;
      ptr_q  <= 6'd0;
      rep_q  <= 7'd0;
    end
    else if (!run)
    begin
      slot_q <= 2'd0;
      ptr_q  <= 6'd0;
      rep_q  <= 7'd0;
    end
    else if (step)
    begin
      ptr_q  <= (last_bit | slot_done) ? 6'd0 : ptr_q + 6'd1;
      rep_q  <= slot_done ? 7'd0 : (last_bit ? rep_q + 7'd1 : rep_q);
      slot_q <= slot_done ? ((slot_q == 2'd2) ? 2'd0 : slot_q + 2'd1) : slot_q;
    end
  end

  assign beat.src       = cur_src;
  assign beat.ptr       = ptr_q;
  assign beat.mod_bit   = mod_of(ctl.mod_pick, ptr_q);
  assign beat.const_bit = ctl.const_val;

  // ==========================================================================
  // checks
  a_loop_restart: assert property (@(posedge pclk) disable iff (!presetn)
    loop_end |=> (slot_q == 2'd0) && (ptr_q == 6'd0))
    else $error("loop did not restart at first slot");

endmodule
`default_nettype wire

/* File: hdl/lbe_engine.sv */
// link lane self-test engine: apb registers, pattern transmitter and receiver checker
`timescale 1ns/1ps
`default_nettype none
module lbe_engine
  import lbe_pkg::*;
(
  // clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [APB_AW-1:0]     paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // link
  input  wire logic                  link_clk_i,
  input  wire lbe_lanes_t [1:0]      rx_lanes_i,
  output lbe_lanes_t      [1:0]      tx_lanes_o,
  // status
  output logic                       test_running
);

  // ==========================================================================
  // helpers
  function automatic logic [3:0] popcount(input logic [8:0] v);
    popcount = 4'h0;
    for (int i = 0; i < 9; i++)
    begin
      popcount = popcount + 4'(v[i]);
    end
  endfunction

  function automatic logic [4:0] top_lane(input logic [8:0] v);
    top_lane = 5'h00;
    for (int i = 0; i < 9; i++)
    begin
      if (v[i])
      begin
        top_lane = 5'(i);
      end
    end
  endfunction

  function automatic logic [17:0] rotate(input logic [17:0] inv, input logic [1:0] ring);
    rotate = inv;
    case (ring)
      RING_16: rotate = {inv[16:0], inv[17]};
      RING_8:  rotate = {inv[17:9], inv[7:0], inv[8]};
      RING_2:
      begin
        rotate[8] = inv[1];
        rotate[1] = inv[0];
        rotate[0] = inv[8];
      end
      default: rotate = inv;
    endcase
  endfunction

  // ==========================================================================
  // registers
  logic        rot_on_q;
  logic        rx_off_q;
  logic [10:0] tally_q;
  logic [4:0]  lane_idx_q;
  logic [1:0]  stat_q;
  lbe_pattern_control_t pattern_control_q;
  logic [23:0] pbuf1_q;
  logic [23:0] pbuf2_q;
  logic [31:0] ext_q;
  logic [17:0] mask_q;
  logic [17:0] inv_q;
  logic [17:0] pb2sel_q;
  logic [17:0] scr_q;
  logic [17:0] flags_q;
  logic        run_q;
  logic        link32_q;
  logic [1:0]  group_q;
  logic [1:0]  ring_q;
  logic [31:0] prdata_q;

  // ==========================================================================
  // apb decode
  logic        wr;
  logic        hit;
  logic        wr_bist;
  logic        wr_inv;
  logic        wr_flags;
  logic [31:0] rd_word;

  assign wr       = psel & penable & pwrite & hit;
  assign hit      = (paddr[1:0] == 2'b00) && (paddr <= OFF_ENGINE_CTL);
  assign wr_bist  = wr & (paddr == OFF_BIST_CTL);
  assign wr_inv   = wr & (paddr == OFF_INVERT);
  assign wr_flags = wr & (paddr == OFF_ERR_FLAGS);
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~hit;
  assign prdata   = prdata_q;

  always_comb
  begin
    case (paddr)
      OFF_BIST_CTL:   rd_word = {ENGINE_IS_16, 4'h0, tally_q, 3'h0, lane_idx_q,
                                 stat_q, rot_on_q, 3'h0, rx_off_q, 1'b0};
      OFF_PAT_CTL:    rd_word = {6'h00, pattern_control_q};
      OFF_PBUF1:      rd_word = {8'h00, pbuf1_q};
      OFF_MASK:       rd_word = {14'h0000, mask_q};
      OFF_INVERT:     rd_word = {14'h0000, inv_q};
      OFF_PBUF2:      rd_word = {8'h00, pbuf2_q};
      OFF_PB2_SELECT: rd_word = {14'h0000, pb2sel_q};
      OFF_PBUF_EXT:   rd_word = ext_q;
      OFF_SCRAMBLE:   rd_word = {14'h0000, scr_q};
      OFF_ERR_FLAGS:  rd_word = {14'h0000, flags_q};
      OFF_ENGINE_CTL: rd_word = {24'h000000, ring_q, group_q, 1'b0, link32_q, 1'b0, run_q};
      default:        rd_word = 32'h00000000;
    endcase
  end

  // ==========================================================================
  // link clock edge and receive pin synchronisers
  logic             lclk_s1_q;
  logic             lclk_s2_q;
  logic             lclk_s3_q;
  lbe_lanes_t [1:0] rx_s1_q;
  lbe_lanes_t [1:0] rx_s2_q;
  logic             bit_en;

  assign bit_en = lclk_s2_q & ~lclk_s3_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lclk_s1_q <= 1'b0;
      lclk_s2_q <= 1'b0;
      lclk_s3_q <= 1'b0;
      rx_s1_q   <= '0;
      rx_s2_q   <= '0;
    end
    else
    begin
      lclk_s1_q <= link_clk_i;
      lclk_s2_q <= lclk_s1_q;
      lclk_s3_q <= lclk_s2_q;
      rx_s1_q   <= rx_lanes_i;
      rx_s2_q   <= rx_s1_q;
    end
  end

  // ==========================================================================
  // pattern sources and lane shaping
  lbe_beat_t      beat;
  logic           loop_end;
  logic [39:0]    buf1;
  logic [39:0]    buf2;
  logic [22:0]    lfsr_q;
  logic [8:0]     buf_bit;
  logic [8:0]     src_bit;
  logic [8:0]     tx_bit;
  logic [8:0]     tx_q;
  lbe_lanes_t     tx_word;

  lbe_pat_seq u_seq (
    .pclk     (pclk),
    .presetn  (presetn),
    .run      (run_q),
    .bit_en   (bit_en),
    .ctl      (pattern_control_q),
    .beat     (beat),
    .loop_end (loop_end)
  );

  assign buf1 = {ext_q[15:0], pbuf1_q};
  assign buf2 = {ext_q[31:16], pbuf2_q};

  for (genvar g = 0; g < ENG_LANES; g++)
  begin : g_lane
    assign buf_bit[g] = pb2sel_q[g] ? buf2[beat.ptr] : buf1[beat.ptr];
    assign src_bit[g] = (beat.src == SRC_BUF) ? buf_bit[g] :
                        (beat.src == SRC_MOD) ? beat.mod_bit : beat.const_bit;
    assign tx_bit[g]  = (mask_q[g] & (src_bit[g] ^ inv_q[g])) ^ (scr_q[g] & lfsr_q[22]);
  end

  // same byte pattern on both halves and both words
  assign tx_word    = {tx_q[8], tx_q[7:0], tx_q[8], tx_q[7:0]};
  assign tx_lanes_o = {tx_word, tx_word};
  assign test_running = run_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_q   <= 9'h000;
      lfsr_q <= SCR_SEED;
    end
    else if (!run_q)
    begin
      tx_q   <= 9'h000;
      lfsr_q <= SCR_SEED;
    end
    else if (bit_en)
    begin
      tx_q   <= tx_bit;
      lfsr_q <= {lfsr_q[21:0], lfsr_q[22] ^ lfsr_q[17]};
    end
  end

  // ==========================================================================
  // receiver check
  logic [1:0]  port_sel;
  lbe_lanes_t  rx_word;
  logic [8:0]  rx_pick;
  logic        armed_q;
  logic        check_en;
  logic [8:0]  err_vec;
  logic        any_err;
  logic [4:0]  hi_lane;

  assign port_sel = link32_q ? group_q : {1'b0, group_q[1]};
  assign rx_word  = rx_s2_q[port_sel[1]];
  assign rx_pick  = port_sel[0] ? {rx_word.ctl1, rx_word.cad_hi} : {rx_word.ctl0, rx_word.cad_lo};
  assign check_en = bit_en & run_q & ~rx_off_q & armed_q;
  assign err_vec  = (rx_pick ^ tx_q) & mask_q[8:0] & {9{check_en}};
  assign any_err  = |err_vec;
  assign hi_lane  = top_lane(err_vec);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      armed_q <= 1'b0;
    end
    else
    begin
      armed_q <= run_q & (armed_q | bit_en);
    end
  end

  // ==========================================================================
  // error status, tally and flags
  logic        tally_clr;
  logic [11:0] tally_sum;
  logic [10:0] tally_d;
  logic        stat_clr;
  logic        first_err;
  logic [1:0]  stat_d;
  logic [4:0]  lane_idx_d;
  logic [17:0] flags_d;
  logic [17:0] inv_d;

  assign tally_clr  = wr_bist & (pwdata[TALLY_LSB +: 11] == TALLY_MAX);
  assign tally_sum  = {1'b0, tally_clr ? 11'h000 : tally_q} + {8'h00, popcount(err_vec)};
  assign tally_d    = tally_sum[11] ? TALLY_MAX : tally_sum[10:0];
  assign stat_clr   = wr_bist & (pwdata[ERR_STAT_LSB +: 2] == STAT_CLEAR);
  assign first_err  = any_err & ((stat_q == STAT_NONE) | stat_clr);
  assign stat_d     = any_err ? STAT_MISCMP : (stat_clr ? STAT_NONE : stat_q);
  assign lane_idx_d = first_err ? hi_lane :
                      ((wr_bist & (pwdata[ERR_LANE_LSB +: 5] == LANE_CLEAR)) ? 5'h00 : lane_idx_q);
  assign flags_d    = (wr_flags ? (flags_q & pwdata[17:0]) : flags_q) | {9'h000, err_vec};
  assign inv_d      = wr_inv ? pwdata[17:0] :
                      ((loop_end & rot_on_q) ? rotate(inv_q, ring_q) : inv_q);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tally_q    <= 11'h000;
      stat_q     <= STAT_NONE;
      lane_idx_q <= 5'h00;
      flags_q    <= 18'h00000;
      inv_q      <= 18'h00000;
    end
    else
    begin
      tally_q    <= tally_d;
      stat_q     <= stat_d;
      lane_idx_q <= lane_idx_d;
      flags_q    <= flags_d;
      inv_q      <= inv_d;
    end
  end

  // ==========================================================================
  // plain read/write registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rot_on_q <= 1'b0;
      rx_off_q <= 1'b0;
      pattern_control_q <= '0;
      pbuf1_q  <= RST_PBUF1;
      pbuf2_q  <= RST_PBUF2;
      ext_q    <= RST_PBUF_EXT;
      mask_q   <= RST_MASK;
      pb2sel_q <= 18'h00000;
      scr_q    <= 18'h00000;
      run_q    <= 1'b0;
      link32_q <= 1'b0;
      group_q  <= 2'b00;
      ring_q   <= RING_16;
      prdata_q <= 32'h00000000;
    end
    else
    begin
      if (psel & ~penable)
      begin
        prdata_q <= rd_word;
      end
      if (wr_bist)
      begin
        rot_on_q <= pwdata[ROT_ON_BIT];
        rx_off_q <= pwdata[RX_OFF_BIT];
      end
      if (wr & (paddr == OFF_PAT_CTL))
      begin
        pattern_control_q <= pwdata[25:0];
      end
      if (wr & (paddr == OFF_PBUF1))
      begin
        pbuf1_q <= pwdata[23:0];
      end
      if (wr & (paddr == OFF_PBUF2))
      begin
        pbuf2_q <= pwdata[23:0];
      end
      if (wr & (paddr == OFF_PBUF_EXT))
      begin
        ext_q <= pwdata;
      end
      if (wr & (paddr == OFF_MASK))
      begin
        mask_q <= pwdata[17:0];
      end
      if (wr & (paddr == OFF_PB2_SELECT))
      begin
        pb2sel_q <= pwdata[17:0];
      end
      if (wr & (paddr == OFF_SCRAMBLE))
      begin
        scr_q <= pwdata[17:0];
      end
      if (wr & (paddr == OFF_ENGINE_CTL))
      begin
        run_q    <= pwdata[RUN_BIT];
        link32_q <= pwdata[LINK32_BIT];
        group_q  <= pwdata[GROUP_LSB +: 2];
        ring_q   <= pwdata[RING_LSB +: 2];
      end
    end
  end

  // ==========================================================================
  // checks
  a_tally_saturate: assert property (@(posedge pclk) disable iff (!presetn)
    (tally_q == TALLY_MAX) && !wr_bist |=> (tally_q == TALLY_MAX))
    else $error("error tally wrapped past its maximum");

  a_tally_count: assert property (@(posedge pclk) disable iff (!presetn)
    !wr_bist && (tally_q < 11'h7F0) && (err_vec == 9'h003) |=> (tally_q == $past(tally_q) + 11'h002))
    else $error("error tally did not add two lane errors");

  a_tally_clear: assert property (@(posedge pclk) disable iff (!presetn)
    wr_bist && (pwdata[26:16] == 11'h7FF) && !any_err |=> (tally_q == 11'h000))
    else $error("all-ones write did not clear error tally");

  a_tally_keep: assert property (@(posedge pclk) disable iff (!presetn)
    wr_bist && (pwdata[26:16] == 11'h000) && !any_err |=> $stable(tally_q))
    else $error("all-zeros write changed error tally");

  a_width_bit: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && (paddr == OFF_BIST_CTL) |=> (prdata[31] == 1'b0))
    else $error("engine width bit does not read as 8-bit");

  a_halves_same: assert property (@(posedge pclk) disable iff (!presetn)
    (tx_lanes_o[0].cad_hi == tx_lanes_o[0].cad_lo) && (tx_lanes_o[1] == tx_lanes_o[0]))
    else $error("upper and lower lanes carry different patterns");

  a_mask_zero: assert property (@(posedge pclk) disable iff (!presetn)
    bit_en && run_q |=> ((tx_q & ~$past(mask_q[8:0]) & ~$past(scr_q[8:0])) == 9'h000))
    else $error("masked unscrambled lane did not send zero");

  a_flags_clear: assert property (@(posedge pclk) disable iff (!presetn)
    wr_flags && (pwdata[17:0] == 18'h00000) && !any_err |=> (flags_q == 18'h00000))
    else $error("zero write did not clear lane error flags");

  a_first_lane: assert property (@(posedge pclk) disable iff (!presetn)
    any_err && (stat_q == STAT_NONE) |=> (lane_idx_q == $past(hi_lane)) && (stat_q == STAT_MISCMP))
    else $error("first error lane not recorded");

  a_rotate_ring: assert property (@(posedge pclk) disable iff (!presetn)
    loop_end && rot_on_q && !wr_inv && (ring_q == RING_16) |=>
    (inv_q == {$past(inv_q[16:0]), $past(inv_q[17])}))
    else $error("inversion bits did not rotate left at loop end");

endmodule
`default_nettype wire

/* File: bench/lbe_peer.sv */
// loopback peer: link clock, lane echo, one-bit error injector
`timescale 1ns/1ps
`default_nettype none
module lbe_peer
  import lbe_pkg::*;
(
  // control
  input  wire logic             en,
  input  wire logic             inj,
  input  wire logic             stuck,
  // link
  input  wire lbe_lanes_t [1:0] tx,
  output logic                  lclk,
  output lbe_lanes_t      [1:0] rx
);
  logic flip = 1'b0;
  logic shot = 1'b0;
  // clock rests low outside a test
  initial
  begin
    lclk = 1'b0;
    forever
    begin
      #80;
      lclk = en ? ~lclk : 1'b0;
    end
  end
  // one bit-time, falling edge to falling edge
  always @(negedge lclk)
  begin
    flip <= inj & ~shot;
    shot <= inj;
  end
  assign rx[1] = tx[1];
  // stuck inverts lanes 0 and 1 for as long as it is held
  assign rx[0] = tx[0] ^ {9'h0, flip, 6'h0, stuck, stuck};
endmodule
`default_nettype wire

/* File: bench/tb.sv */
// self-checking bench of the lane self-test engine
`timescale 1ns/1ps
`default_nettype none
module tb;
  import lbe_pkg::*;
  logic             pclk = 1'b0;
  logic             presetn = 1'b0;
  logic             psel = 1'b0;
  logic             penable = 1'b0;
  logic             pwrite = 1'b0;
  logic [7:0]       paddr = 8'h00;
  logic [31:0]      pwdata = 32'h0;
  logic [31:0]      prdata;
  logic             pready;
  logic             pslverr;
  logic             lclk;
  logic             lon = 1'b0;
  logic             inj = 1'b0;
  logic             stuck = 1'b0;
  logic             running;
  lbe_lanes_t [1:0] rx;
  lbe_lanes_t [1:0] tx;
  logic [31:0]      rd;
  logic             er;
  int               n_errors = 0;
  int               num_checks = 0;
  logic [7:0]  ta[8] = '{OFF_PAT_CTL, OFF_PBUF1, OFF_PBUF2, OFF_PBUF_EXT, OFF_MASK, OFF_INVERT,
    OFF_PB2_SELECT, OFF_SCRAMBLE};
  logic [31:0] te[8] = '{32'h03FFFFFF, 32'h00FFFFFF, 32'h00FFFFFF, 32'hFFFFFFFF, 32'h0003FFFF,
    32'h0003FFFF, 32'h0003FFFF, 32'h0003FFFF};
  logic [7:0]  ra[7] = '{OFF_BIST_CTL, OFF_PAT_CTL, OFF_MASK, OFF_INVERT, OFF_PB2_SELECT,
    OFF_SCRAMBLE, OFF_ERR_FLAGS};
  logic [31:0] re[7] = '{32'h0, 32'h0, 32'h0003FFFF, 32'h0, 32'h0, 32'h0, 32'h0};

  lbe_engine uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_clk_i(lclk), .rx_lanes_i(rx), .tx_lanes_o(tx), .test_running(running));
  lbe_peer peer (.en(lon), .inj(inj), .stuck(stuck), .tx(tx), .lclk(lclk), .rx(rx));

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic conclude();
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // one apb transfer, result left in rd and er
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    n = 0;
    while (pready !== 1'b1 && n < 50)
    begin
      @(posedge pclk);
      n++;
    end
    if (n == 50)
    begin
      n_errors++;
      conclude();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  initial
  begin
    forever #10 pclk = ~pclk;
  end

  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      apb(1'b1, ta[i], 32'hFFFFFFFF);
      apb(1'b0, ta[i], 32'h0);
      chk(rd, te[i]);
    end
    apb(1'b0, 8'h2C, 32'h0);
    chk({31'h0, er}, 32'h1);
    // second reset restores the table
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 7; i++)
    begin
      apb(1'b0, ra[i], 32'h0);
      chk(rd, re[i]);
    end
    apb(1'b1, OFF_PAT_CTL, 32'h8);
    apb(1'b1, OFF_MASK, 32'h3FEFF);
    apb(1'b1, OFF_ENGINE_CTL, 32'h1);
    lon <= 1'b1;
    repeat (200) @(posedge pclk);
    chk(32'(tx[0].ctl0), 32'h0);
    chk({31'h0, running}, 32'h1);
    for (int k = 0; k < 2; k++)
    begin
      if (k == 1)
        apb(1'b1, OFF_MASK, 32'h3FFFF);
      repeat (100) @(posedge pclk);
      inj <= 1'b1;
      repeat (40) @(posedge pclk);
      chk(32'(tx[1]), 32'(tx[0]));
      inj <= 1'b0;
      repeat (40) @(posedge pclk);
      apb(1'b0, OFF_BIST_CTL, 32'h0);
      chk(rd, (k == 1) ? 32'h00010880 : 32'h0);
      apb(1'b0, OFF_ERR_FLAGS, 32'h0);
      chk(rd, (k == 1) ? 32'h100 : 32'h0);
    end
    apb(1'b1, OFF_BIST_CTL, 32'h0);
    apb(1'b0, OFF_BIST_CTL, 32'h0);
    chk(rd, 32'h00010880);
    apb(1'b1, OFF_BIST_CTL, 32'h07FF1FC0);
    apb(1'b0, OFF_BIST_CTL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, OFF_ERR_FLAGS, 32'h0);
    apb(1'b0, OFF_ERR_FLAGS, 32'h0);
    chk(rd, 32'h0);
    // exactly 40 link bit-times: one loop of the 40-bit buffer, one rotation
    lon <= 1'b0;
    apb(1'b1, OFF_ENGINE_CTL, 32'h0);
    apb(1'b1, OFF_INVERT, 32'h00201);
    apb(1'b1, OFF_BIST_CTL, 32'h20);
    apb(1'b1, OFF_ENGINE_CTL, 32'h1);
    lon <= 1'b1;
    repeat (320) @(posedge pclk);
    lon <= 1'b0;
    repeat (10) @(posedge pclk);
    apb(1'b0, OFF_INVERT, 32'h0);
    chk(rd, 32'h00402);
    // lanes 0 and 1 fail every bit-time until the tally saturates
    lon <= 1'b1;
    stuck <= 1'b1;
    repeat (9000) @(posedge pclk);
    stuck <= 1'b0;
    repeat (40) @(posedge pclk);
    apb(1'b0, OFF_BIST_CTL, 32'h0);
    chk(rd, 32'h07FF01A0);
    apb(1'b0, OFF_ERR_FLAGS, 32'h0);
    chk(rd, 32'h003);
    conclude();
  end
endmodule
`default_nettype wire
